// ### hdl/object_graphics_pkg.sv
package object_graphics_pkg;

  // line timing in colour clocks
  localparam logic [7:0] LINE_CLOCKS    = 8'h00E4;
  localparam logic [7:0] BLANK_CLOCKS   = 8'h0044;
  localparam logic [7:0] VISIBLE_CLOCKS = 8'h00A0;
  localparam logic [7:0] HALF_CLOCKS    = 8'h0050;
  localparam logic [5:0] FIELD_BITS     = 6'h14;

  // register word indices (byte address = 4 * index)
  localparam logic [4:0] IDX_FIELD_CONTROL = 5'h00;
  localparam logic [4:0] IDX_FIELD0        = 5'h01;
  localparam logic [4:0] IDX_FIELD1        = 5'h02;
  localparam logic [4:0] IDX_FIELD2        = 5'h03;
  localparam logic [4:0] IDX_COPIES_SIZE0  = 5'h04;
  localparam logic [4:0] IDX_COPIES_SIZE1  = 5'h05;
  localparam logic [4:0] IDX_MIRROR0       = 5'h06;
  localparam logic [4:0] IDX_MIRROR1       = 5'h07;
  localparam logic [4:0] IDX_GRAPHICS0     = 5'h08;
  localparam logic [4:0] IDX_GRAPHICS1     = 5'h09;
  localparam logic [4:0] IDX_MISSILE0_ON   = 5'h0A;
  localparam logic [4:0] IDX_MISSILE1_ON   = 5'h0B;
  localparam logic [4:0] IDX_BALL_ON       = 5'h0C;
  localparam logic [4:0] IDX_P0_DELAY      = 5'h0D;
  localparam logic [4:0] IDX_P1_DELAY      = 5'h0E;
  localparam logic [4:0] IDX_BALL_DELAY    = 5'h0F;
  localparam logic [4:0] IDX_M0_LOCK       = 5'h10;
  localparam logic [4:0] IDX_M1_LOCK       = 5'h11;
  localparam logic [4:0] IDX_SHIFT_BASE    = 5'h12;
  localparam logic [4:0] IDX_APPLY_SHIFT   = 5'h17;
  localparam logic [4:0] IDX_CLEAR_SHIFT   = 5'h18;
  localparam logic [4:0] IDX_RESET_BASE    = 5'h19;
  localparam logic [4:0] IDX_WAIT_LINE     = 5'h1E;
  localparam logic [4:0] IDX_STATUS        = 5'h1F;

  // object numbering for shift and reset blocks
  localparam int OBJ_P0 = 0;
  localparam int OBJ_P1 = 1;
  localparam int OBJ_M0 = 2;
  localparam int OBJ_M1 = 3;
  localparam int OBJ_BL = 4;
  localparam int OBJECTS = 5;

  // field positions
  localparam int CTRL_REFLECT  = 0;
  localparam int CTRL_SCORE    = 1;
  localparam int CTRL_PRIORITY = 2;
  localparam int SIZE_LO       = 4;
  localparam int MIRROR_BIT    = 3;
  localparam int ON_BIT        = 1;
  localparam int LOCK_BIT      = 1;
  localparam int DELAY_BIT     = 0;
  localparam int STAT_BLANK    = 8;
  localparam int STAT_WAIT     = 9;

  // copy decodes of the position counters
  localparam logic [7:0] COPY_CLOSE  = 8'h10;
  localparam logic [7:0] COPY_MEDIUM = 8'h20;
  localparam logic [7:0] COPY_WIDE   = 8'h40;
  localparam logic [7:0] CENTRE_BASE = 8'h04;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic playfield;
    logic player0;
    logic player1;
    logic missile0;
    logic missile1;
    logic ball;
  } pixels_s;

  typedef struct packed {
    logic playfield;
    logic player1;
    logic player0;
    logic background;
  } select_s;

endpackage

// ### hdl/tv_object_graphics.sv
`timescale 1ns/1ns
`default_nettype none

module tv_object_graphics #(
  parameter int ADDR_WIDTH = 12
) (
  // clock and reset
  input  wire logic                              sys_clk,
  input  wire logic                              reset,
  // axi4-lite write
  input  wire logic [ADDR_WIDTH-1:0]             s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output var  logic                              s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output var  logic                              s_axi_wready,
  output var  logic [1:0]                        s_axi_bresp,
  output var  logic                              s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  // axi4-lite read
  input  wire logic [ADDR_WIDTH-1:0]             s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output var  logic                              s_axi_arready,
  output var  logic [31:0]                       s_axi_rdata,
  output var  logic [1:0]                        s_axi_rresp,
  output var  logic                              s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  // video side
  output var  object_graphics_pkg::pixels_s      object_pixels,
  output var  object_graphics_pkg::select_s      color_select,
  output var  logic                              line_blank
);

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  logic [7:0]            regs [32];
  logic                  aw_held;
  logic                  w_held;
  logic [ADDR_WIDTH-1:0] aw_addr;
  logic [7:0]            w_data;
  logic                  w_lane0;
  logic                  next_aw_held;
  logic                  next_w_held;
  logic                  next_bvalid;
  logic                  next_rvalid;
  logic                  do_write;
  logic [ADDR_WIDTH-1:0] wr_addr;
  logic [7:0]            wr_data;
  logic                  wr_lane0;
  logic [4:0]            wr_idx;
  logic                  wr_mapped;
  logic                  ar_take;
  logic [7:0]            hcount;
  logic                  wait_flag;

  always_comb
  begin
    wr_addr  = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr;
    wr_data  = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata[7:0] : w_data;
    wr_lane0 = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb[0] : w_lane0;
    next_aw_held = aw_held || (s_axi_awvalid && s_axi_awready);
    next_w_held  = w_held || (s_axi_wvalid && s_axi_wready);
    do_write = next_aw_held && next_w_held && !s_axi_bvalid;
    if (do_write)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
    end
    next_bvalid = do_write || (s_axi_bvalid && !s_axi_bready);
    ar_take     = s_axi_arvalid && s_axi_arready;
    next_rvalid = ar_take || (s_axi_rvalid && !s_axi_rready);
    wr_idx      = wr_addr[6:2];
    wr_mapped   = (wr_addr >> 7) == '0;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_addr       <= '0;
      w_data        <= 8'h0000;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= object_graphics_pkg::RESP_OKAY;
    end
    else
    begin
      aw_held       <= next_aw_held;
      w_held        <= next_w_held;
      s_axi_awready <= !next_aw_held && !next_bvalid;
      s_axi_wready  <= !next_w_held && !next_bvalid;
      s_axi_bvalid  <= next_bvalid;
      if (s_axi_awvalid && s_axi_awready)
        aw_addr <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_data  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end
      if (do_write)
        s_axi_bresp <= wr_mapped ? object_graphics_pkg::RESP_OKAY : object_graphics_pkg::RESP_SLVERR;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= object_graphics_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !next_rvalid;
      s_axi_rvalid  <= next_rvalid;
      if (ar_take)
      begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= object_graphics_pkg::RESP_OKAY;
        if ((s_axi_araddr >> 7) != '0)
          s_axi_rresp <= object_graphics_pkg::RESP_SLVERR;
        else if (s_axi_araddr[6:2] == object_graphics_pkg::IDX_STATUS)
        begin
          s_axi_rdata[7:0] <= hcount;
          s_axi_rdata[object_graphics_pkg::STAT_BLANK] <= hcount < object_graphics_pkg::BLANK_CLOCKS;
          s_axi_rdata[object_graphics_pkg::STAT_WAIT]  <= wait_flag;
        end
        else
          s_axi_rdata[7:0] <= regs[s_axi_araddr[6:2]];
      end
    end
  end

  // strobe decode, qualified only by address
  logic                                   write_hit;
  logic [object_graphics_pkg::OBJECTS-1:0] pos_reset;
  logic                                   apply_shift_strobe;
  logic                                   clear_shift_strobe;
  logic                                   wait_line_strobe;

  always_comb
  begin
    write_hit = do_write && wr_mapped;
    apply_shift_strobe = write_hit && wr_idx == object_graphics_pkg::IDX_APPLY_SHIFT;
    clear_shift_strobe = write_hit && wr_idx == object_graphics_pkg::IDX_CLEAR_SHIFT;
    wait_line_strobe   = write_hit && wr_idx == object_graphics_pkg::IDX_WAIT_LINE;
    for (int k = 0; k < object_graphics_pkg::OBJECTS; k++)
      pos_reset[k] = write_hit && wr_idx == object_graphics_pkg::IDX_RESET_BASE + 5'(k);
  end

  logic [7:0] p0_delayed;
  logic [7:0] p1_delayed;
  logic       ball_delayed;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      for (int k = 0; k < 32; k++)
        regs[k] <= object_graphics_pkg::REG_RESET;
    end
    else
    begin
      if (write_hit && wr_lane0)
        regs[wr_idx] <= wr_data;
      if (clear_shift_strobe)
        for (int k = 0; k < object_graphics_pkg::OBJECTS; k++)
          regs[object_graphics_pkg::IDX_SHIFT_BASE + 5'(k)] <= 8'h0000;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      p0_delayed <= 8'h0000;
      p1_delayed <= 8'h0000;
    end
    else if (write_hit && wr_idx == object_graphics_pkg::IDX_GRAPHICS0)
      p1_delayed <= regs[object_graphics_pkg::IDX_GRAPHICS1];
    else if (write_hit && wr_idx == object_graphics_pkg::IDX_GRAPHICS1)
      p0_delayed <= regs[object_graphics_pkg::IDX_GRAPHICS0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // line timing

  logic blank;
  logic [7:0] xpos;
  logic line_end;

  assign blank    = hcount < object_graphics_pkg::BLANK_CLOCKS;
  assign xpos     = hcount - object_graphics_pkg::BLANK_CLOCKS;
  assign line_end = hcount == object_graphics_pkg::LINE_CLOCKS - 8'h0001;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      hcount <= 8'h0000;
    else
      hcount <= line_end ? 8'h0000 : hcount + 8'h0001;
  end

  // set wins over the clear at the line end
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      wait_flag <= 1'b0;
    else if (wait_line_strobe)
      wait_flag <= 1'b1;
    else if (line_end)
      wait_flag <= 1'b0;
  end

  // ball value of the previous line
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      ball_delayed <= 1'b0;
    else if (line_end)
      ball_delayed <= regs[object_graphics_pkg::IDX_BALL_ON][object_graphics_pkg::ON_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // position counters, motion and serializers

  logic [7:0] pos    [object_graphics_pkg::OBJECTS];
  logic [5:0] scan   [object_graphics_pkg::OBJECTS];
  logic [5:0] width  [object_graphics_pkg::OBJECTS];
  logic [1:0] scale  [2];
  logic [object_graphics_pkg::OBJECTS-1:0] active;
  logic [object_graphics_pkg::OBJECTS-1:0] tick;
  logic [object_graphics_pkg::OBJECTS-1:0] start;
  logic [object_graphics_pkg::OBJECTS-1:0] locked;
  logic [object_graphics_pkg::OBJECTS-1:0] shown;
  logic [5:0]                              cur_scan [object_graphics_pkg::OBJECTS];

  genvar gi;
  generate
    for (gi = 0; gi < object_graphics_pkg::OBJECTS; gi++)
    begin : g_obj
      localparam int PLAYER = gi % 2;
      logic signed [3:0] motion;
      logic [7:0]        nus;
      logic [7:0]        centre;
      logic [8:0]        lock_sum;

      assign nus    = regs[object_graphics_pkg::IDX_COPIES_SIZE0 + 5'(PLAYER)];
      assign centre = object_graphics_pkg::CENTRE_BASE << scale[PLAYER];
      assign lock_sum = {1'b0, pos[PLAYER]} + {1'b0, object_graphics_pkg::VISIBLE_CLOCKS} - {1'b0, centre};
      // visible clocks, plus or minus motion clocks
      assign tick[gi] = (!blank && motion >= 0) || (blank && motion > 0);
      // first pixel shows in the decode cycle, so a reset in blank lands on the left edge
      assign shown[gi]    = (tick[gi] && start[gi]) || active[gi];
      assign cur_scan[gi] = (tick[gi] && start[gi]) ? 6'h00 : scan[gi];

      always_comb
      begin
        locked[gi] = 1'b0;
        if (gi == object_graphics_pkg::OBJ_BL)
        begin
          width[gi] = 6'h01 << regs[object_graphics_pkg::IDX_FIELD_CONTROL][5:4];
          start[gi] = pos[gi] == 8'h0000;
        end
        else
        begin
          // copy decodes shared by player and missile
          start[gi] = pos[gi] == 8'h0000
            || (pos[gi] == object_graphics_pkg::COPY_CLOSE && (nus[2:0] == 3'h1 || nus[2:0] == 3'h3))
            || (pos[gi] == object_graphics_pkg::COPY_MEDIUM
                && (nus[2:0] == 3'h2 || nus[2:0] == 3'h3 || nus[2:0] == 3'h6))
            || (pos[gi] == object_graphics_pkg::COPY_WIDE && (nus[2:0] == 3'h4 || nus[2:0] == 3'h6));
          if (gi < object_graphics_pkg::OBJ_M0)
            width[gi] = 6'h08 << scale[PLAYER];
          else
          begin
            width[gi] = 6'h01 << nus[5:4];
            locked[gi] = regs[object_graphics_pkg::IDX_M0_LOCK + 5'(PLAYER)][object_graphics_pkg::LOCK_BIT];
          end
        end
      end

      // signed motion loaded only on apply
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          motion <= 4'sh0;
        else if (apply_shift_strobe)
          motion <= signed'(regs[object_graphics_pkg::IDX_SHIFT_BASE + 5'(gi)][7:4]);
        else if (blank && motion > 0)
          motion <= motion - 4'sh1;
        else if (!blank && motion < 0)
          motion <= motion + 4'sh1;
      end

      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
          pos[gi] <= 8'h0000;
        else if (pos_reset[gi])
          pos[gi] <= 8'h0000;
        else if (locked[gi])
          pos[gi] <= lock_sum >= {1'b0, object_graphics_pkg::VISIBLE_CLOCKS}
            ? 8'(lock_sum - {1'b0, object_graphics_pkg::VISIBLE_CLOCKS}) : lock_sum[7:0];
        else if (tick[gi])
          pos[gi] <= pos[gi] == object_graphics_pkg::VISIBLE_CLOCKS - 8'h0001 ? 8'h0000 : pos[gi] + 8'h0001;
      end

      // scan runs only after a start decode
      always_ff @(posedge sys_clk or posedge reset)
      begin
        if (reset)
        begin
          active[gi] <= 1'b0;
          scan[gi]   <= 6'h00;
        end
        else if (tick[gi] && start[gi])
        begin
          active[gi] <= width[gi] != 6'h01;
          scan[gi]   <= 6'h01;
        end
        else if (tick[gi] && active[gi])
        begin
          scan[gi]   <= scan[gi] + 6'h01;
          active[gi] <= scan[gi] != width[gi] - 6'h01;
        end
      end
    end
  endgenerate

  always_comb
  begin
    for (int k = 0; k < 2; k++)
    begin
      case (regs[object_graphics_pkg::IDX_COPIES_SIZE0 + 5'(k)][2:0])
        3'h5:    scale[k] = 2'h1;
        3'h7:    scale[k] = 2'h2;
        default: scale[k] = 2'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pixels and priority

  logic [19:0] field_vec;
  logic [5:0]  field_cell;
  logic [4:0]  field_bit;
  logic [7:0]  gfx [2];
  logic [2:0]  bit_pos [2];
  object_graphics_pkg::pixels_s pix;
  object_graphics_pkg::select_s next_select;
  logic        left_half;
  logic        field_any;

  always_comb
  begin
    // field bits 4, 8, 8 left to right
    field_vec[3:0]   = regs[object_graphics_pkg::IDX_FIELD0][7:4];
    for (int k = 0; k < 8; k++)
      field_vec[4 + k] = regs[object_graphics_pkg::IDX_FIELD1][7 - k];
    field_vec[19:12] = regs[object_graphics_pkg::IDX_FIELD2];
    field_cell = xpos[7:2];
    left_half  = xpos < object_graphics_pkg::HALF_CLOCKS;
    // left scan, then repeat or mirror
    if (left_half)
      field_bit = field_cell[4:0];
    else if (regs[object_graphics_pkg::IDX_FIELD_CONTROL][object_graphics_pkg::CTRL_REFLECT])
      field_bit = 5'(6'h27 - field_cell);
    else
      field_bit = 5'(field_cell - object_graphics_pkg::FIELD_BITS);
    pix.playfield = !blank && field_vec[field_bit];

    for (int k = 0; k < 2; k++)
    begin
      gfx[k] = regs[object_graphics_pkg::IDX_P0_DELAY + 5'(k)][object_graphics_pkg::DELAY_BIT]
        ? (k == 0 ? p0_delayed : p1_delayed) : regs[object_graphics_pkg::IDX_GRAPHICS0 + 5'(k)];
      bit_pos[k] = 3'(cur_scan[k] >> scale[k]);
    end
    pix.player0 = shown[0] && gfx[0][regs[object_graphics_pkg::IDX_MIRROR0][object_graphics_pkg::MIRROR_BIT]
      ? bit_pos[0] : 3'h7 - bit_pos[0]];
    pix.player1 = shown[1] && gfx[1][regs[object_graphics_pkg::IDX_MIRROR1][object_graphics_pkg::MIRROR_BIT]
      ? bit_pos[1] : 3'h7 - bit_pos[1]];
    // missile on bit and lock hide
    pix.missile0 = shown[2] && !locked[2] && regs[object_graphics_pkg::IDX_MISSILE0_ON][object_graphics_pkg::ON_BIT];
    pix.missile1 = shown[3] && !locked[3] && regs[object_graphics_pkg::IDX_MISSILE1_ON][object_graphics_pkg::ON_BIT];
    // ball enable, optionally a line late
    pix.ball = shown[4] && (regs[object_graphics_pkg::IDX_BALL_DELAY][object_graphics_pkg::DELAY_BIT]
      ? ball_delayed : regs[object_graphics_pkg::IDX_BALL_ON][object_graphics_pkg::ON_BIT]);

    next_select = '0;
    field_any   = pix.playfield || pix.ball;
    if (field_any && regs[object_graphics_pkg::IDX_FIELD_CONTROL][object_graphics_pkg::CTRL_PRIORITY])
      next_select.playfield = 1'b1;
    else if (pix.player0 || pix.missile0)
      next_select.player0 = 1'b1;
    else if (pix.player1 || pix.missile1)
      next_select.player1 = 1'b1;
    else if (field_any)
      next_select.playfield = 1'b1;
    else
      next_select.background = 1'b1;
    // score colours on field pixels only
    if (next_select.playfield && pix.playfield && !pix.ball
        && regs[object_graphics_pkg::IDX_FIELD_CONTROL][object_graphics_pkg::CTRL_SCORE])
    begin
      next_select.playfield = 1'b0;
      next_select.player0   = left_half;
      next_select.player1   = !left_half;
    end
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      object_pixels <= '0;
      color_select  <= '{background: 1'b1, default: 1'b0};
      line_blank    <= 1'b1;
    end
    else
    begin
      object_pixels <= pix;
      color_select  <= next_select;
      line_blank    <= blank;
    end
  end

endmodule

`default_nettype wire

// ### verification/video_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module video_monitor (
  // clock and reset
  input wire logic                         sys_clk,
  input wire logic                         reset,
  // watched outputs and the bready input
  input wire logic                         s_axi_bvalid,
  input wire logic                         s_axi_bready,
  input wire object_graphics_pkg::pixels_s object_pixels,
  input wire object_graphics_pkg::select_s color_select,
  input wire logic                         line_blank
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // missiles ride with players, ball with field
  wire logic sp0 = object_pixels.player0 | object_pixels.missile0;
  wire logic sp1 = object_pixels.player1 | object_pixels.missile1;
  wire logic sfd = object_pixels.playfield | object_pixels.ball;
  AST_ONE_HOT: assert property (
    $onehot(color_select)) else $error("select not one-hot");
  AST_VISIBLE: assert property (
    $fell(line_blank) |-> ##159 !line_blank ##1 line_blank) else $error("visible span wrong");
  AST_BLANK: assert property (
    $rose(line_blank) |-> ##67 line_blank ##1 !line_blank) else $error("blank span wrong");
  AST_BG_EMPTY: assert property (
    color_select.background |-> !(sp0 || sp1 || sfd)) else $error("background over object");
  AST_P0_FRONT: assert property (
    sp0 && !sfd |-> color_select.player0) else $error("player0 not shown");
  AST_P1_NEXT: assert property (
    sp1 && !sp0 && !sfd |-> color_select.player1) else $error("player1 not shown");
  AST_FIELD_SEL: assert property (
    color_select.playfield |-> sfd) else $error("field select without field");
  AST_P0_SEL: assert property (
    color_select.player0 |-> sp0 || object_pixels.playfield) else $error("player0 select idle");
  cover property (color_select.player0 && sfd);
  cover property (color_select.playfield && sp0);
  cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind tv_object_graphics video_monitor i_mon (.*);
`default_nettype wire

// ### verification/cpu_bus_model.sv
`timescale 1ns/1ns
`default_nettype none
module cpu_bus_model (
  // clock
  input  wire logic        sys_clk,
  // write side
  output var  logic [11:0] s_axi_awaddr,
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  // read side
  output var  logic [11:0] s_axi_araddr,
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready
);
  int         slow = 0;
  logic [1:0] resp;
  initial
  begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // released lines show inverted values so stale data cannot pass
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 24'h00_0000, d, 4'hF};
    {s_axi_awvalid, s_axi_wvalid} <= 2'h3;
    do
    begin
      @(posedge sys_clk);
      if (s_axi_awready && s_axi_awvalid)
        {s_axi_awvalid, s_axi_awaddr} <= {1'b0, ~a};
      if (s_axi_wready && s_axi_wvalid)
        {s_axi_wvalid, s_axi_wdata} <= {1'b0, ~s_axi_wdata};
    end
    while (s_axi_awvalid || s_axi_wvalid);
    repeat (slow) @(posedge sys_clk);
    s_axi_bready <= 1'b1;
    @(posedge sys_clk iff s_axi_bvalid && s_axi_bready);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    {s_axi_araddr, s_axi_arvalid} <= {a, 1'b1};
    @(posedge sys_clk iff s_axi_arready);
    {s_axi_araddr, s_axi_arvalid} <= {~a, 1'b0};
    repeat (slow) @(posedge sys_clk);
    s_axi_rready <= 1'b1;
    @(posedge sys_clk iff s_axi_rvalid && s_axi_rready);
    {d, resp} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/tv_object_graphics_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tv_object_graphics_tb_top;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        sys_clk, reset, line_blank, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  object_graphics_pkg::pixels_s object_pixels;
  object_graphics_pkg::select_s color_select;
  int          err_total = 0;
  int          check_count = 0;
  logic [31:0] seed = 32'h0001_1CDC;
  tv_object_graphics i_dut (.*);
  cpu_bus_model i_cpu (.*);
  function automatic logic [7:0] rnd();
    repeat (8) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // field bits: first register all ones, second D7 first, third D0 first
  function automatic logic [159:0] pf_exp(logic [7:0] f1, logic [7:0] f2, logic refl);
    logic [19:0]  b;
    logic [159:0] v;
    b[3:0] = 4'hF;
    for (int k = 0; k < 8; k++)
      {b[4+k], b[12+k]} = {f1[7-k], f2[k]};
    for (int x = 0; x < 160; x++)
      v[x] = b[x < 80 ? x / 4 : (refl ? 39 - x / 4 : x / 4 - 20)];
    return v;
  endfunction
  function automatic logic [159:0] pl_exp(logic [7:0] g, logic mir, logic two);
    logic [159:0] v = '0;
    for (int x = 0; x < 8; x++)
      {v[x], v[16+x]} = {2{mir ? g[x] : g[7-x]}} & {1'b1, two};
    return v;
  endfunction
  task automatic check(string what, logic [159:0] exp, logic [159:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("ERROR %s expected %h seen %h", what, exp, got);
      err_total++;
    end
  endtask
  task automatic scan(output logic [159:0] pf, output logic [159:0] p0, output logic [159:0] s0);
    @(negedge sys_clk iff line_blank);
    @(negedge sys_clk iff !line_blank);
    for (int x = 0; x < 160; x++)
    begin
      {pf[x], p0[x], s0[x]} = {object_pixels.playfield, object_pixels.player0, color_select.player0};
      @(negedge sys_clk);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  initial
  begin
    #200_000;
    err_total++;
    conclude;
  end
  initial
  begin
    logic [7:0]   a, b, c, f1, f2;
    logic [31:0]  d;
    logic [159:0] pf, p0, s0, ep, ef;
    logic         r;
    logic [3:0]   mv;
    reset = 1'b1;
    repeat (4) @(posedge sys_clk);
    reset <= 1'b0;
    for (int i = 0; i < 31; i++)
    begin
      i_cpu.rd(12'(i * 4), d);
      check("reset value", 32'h0000_0000, d);
    end
    i_cpu.rd(12'h080, d);
    check("unmapped read", {2'h2, 32'h0000_0000}, {i_cpu.resp, d});
    i_cpu.wr(12'h080, rnd());
    check("unmapped write", 2'h2, i_cpu.resp);
    i_cpu.wr(12'h048, 8'h70);
    i_cpu.wr(12'h060, rnd());
    i_cpu.rd(12'h048, d);
    check("cleared shift", 32'h0000_0000, d);
    for (int run = 0; run < 2; run++)
    begin
      r = run[0];
      i_cpu.slow = run * 2;
      {a, b, c, f1, f2} = {rnd(), rnd(), rnd(), rnd(), rnd()};
      i_cpu.wr(12'h004, 8'hF0);
      i_cpu.wr(12'h008, f1);
      i_cpu.wr(12'h00C, f2);
      i_cpu.wr(12'h000, {5'h00, r, 1'b0, r});
      i_cpu.wr(12'h018, {4'h0, r, 3'h0});
      i_cpu.wr(12'h010, {7'h00, r});
      i_cpu.wr(12'h020, a);
      i_cpu.wr(12'h024, b);
      i_cpu.wr(12'h020, c);
      i_cpu.wr(12'h034, {7'h00, r});
      @(posedge line_blank);
      i_cpu.wr(12'h064, rnd());
      mv = 4'(rnd()) | 4'h8;
      i_cpu.wr(12'h048, {mv, 4'h0});
      i_cpu.wr(12'h078, rnd());
      i_cpu.wr(12'h05C, rnd());
      i_cpu.rd(12'h07C, d);
      check("status wait and blank", 2'h3, d[9:8]);
      scan(pf, p0, s0);
      ef = pf_exp(f1, f2, r);
      // negative motion drops visible ticks, so the player lands further right
      ep = pl_exp(r ? a : c, r, r) << (5'h10 - mv);
      check("field line", ef, pf);
      check("player0 line", ep, p0);
      check("player0 select", r ? ep & ~ef : ep, s0);
    end
    conclude;
  end
endmodule
`default_nettype wire
